// ===== core/rxq_filter_pkg.sv
// constants for the receive queue supervisor and frame acceptance filter
// assumes a byte-wide parallel register port on the core clock
//
// How it works
// - low mark byte location is value*32*2048
// - high mark byte location is value*32*2048
// - enables bits 3..0, status swaps watermark bits
// - fifo overflow latches status bit 3
// - queue overflow latches bit 2, read clears
// - high crossing latches bit 1, read clears
// - low crossing latches bit 0, read clears
// - bit 6 permits non-pause control frames
// - bit 5 permits pause control frames, non-pause need bit 6 too
// - bit 4 zero rejects length mismatches
// - bit 3 permits crc and mii errors
// - bit 2 zero rejects dribble, non-runt non-collided
// - bit 1 permits mii receive errors
// - bit 0 permits broadcast frames
// - control word reached indirectly, four byte lanes
// - control bit 28 disables heartbeat check
// - bit 23 ignores receive while transmitting
// - bit 21 loops transmit into receive path
// - bit 20 full duplex, heartbeat check skipped
// - bit 19 promiscuous, forwards all, default one
// - bit 18 forwards all multicast frames
package rxq_filter_pkg;

    // direct register offsets
    localparam logic [8:0] ADDR_LOW_MARK = 9'h15a;
    localparam logic [8:0] ADDR_HIGH_MARK = 9'h15b;
    localparam logic [8:0] ADDR_IRQ_EN = 9'h15c;
    localparam logic [8:0] ADDR_STATUS = 9'h15d;
    localparam logic [8:0] ADDR_REJECT_CTL = 9'h15e;
    localparam logic [8:0] ADDR_IND_WR_HI = 9'h140;
    localparam logic [8:0] ADDR_IND_WR_LO = 9'h141;
    localparam logic [8:0] ADDR_IND_RD_HI = 9'h142;
    localparam logic [8:0] ADDR_IND_RD_LO = 9'h143;
    localparam logic [8:0] ADDR_IND_DATA = 9'h144;

    // indirect address of the mac control word, lane 0 is bits 31..24
    localparam logic [15:0] IND_CTRL_BASE = 16'h0000;
    localparam int CTRL_LANES = 4;

    // watermark scale: 32 packets of 2048 bytes is a shift by 16
    localparam int MARK_SHIFT = 16;
    localparam int DEPTH_W = 24;

    // status and enable fields
    localparam int ST_FIFO_OVF = 3;
    localparam int ST_QUEUE_OVF = 2;
    localparam int ST_HIGH = 1;
    localparam int ST_LOW = 0;
    localparam int IE_FIFO_OVF = 3;
    localparam int IE_QUEUE_OVF = 2;
    localparam int IE_LOW = 1;
    localparam int IE_HIGH = 0;

    // reject control fields
    localparam int RJ_NONPAUSE = 6;
    localparam int RJ_CTRL = 5;
    localparam int RJ_LEN = 4;
    localparam int RJ_CRC = 3;
    localparam int RJ_DRIBBLE = 2;
    localparam int RJ_MII = 1;
    localparam int RJ_BCAST = 0;

    // mac control word fields
    localparam int CW_HEARTBEAT_OFF = 28;
    localparam int CW_PORT_SELECT = 27;
    localparam int CW_IGNORE_OWN = 23;
    localparam int CW_LOOPBACK = 21;
    localparam int CW_FULL_DUPLEX = 20;
    localparam int CW_PROMISC = 19;
    localparam int CW_ALL_MCAST = 18;
    localparam logic [31:0] CW_RESET = 32'h0008_0000;
    localparam logic [31:0] CW_IMPL_MASK = 32'h18bc_0000;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] STATUS_MASK = 4'hf;

endpackage : rxq_filter_pkg

// ===== core/rxq_filter.sv
// receive queue supervision, frame acceptance filter and mac control word
// assumes register port, queue and mac core signals are on clk; only the
// phy receive pins come from outside and are synchronised here
`timescale 1ns/1ps

module rxq_filter
    import rxq_filter_pkg::*;
#(
    parameter int DEPTH_BITS = DEPTH_W
) (
    input wire logic clk,
    input wire logic rst_b,
    // parallel register port
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic irq,
    // receive queue state from the buffer manager
    input wire logic [DEPTH_BITS-1:0] queue_depth,
    input wire logic queue_overflow,
    input wire logic fifo_overflow,
    // end-of-frame summary from the mac receiver
    input wire logic frame_done,
    input wire logic frame_ctrl,
    input wire logic frame_pause,
    input wire logic frame_len_err,
    input wire logic frame_crc_err,
    input wire logic frame_dribble,
    input wire logic frame_mii_err,
    input wire logic frame_bcast,
    input wire logic frame_mcast,
    input wire logic frame_addr_match,
    input wire logic frame_runt,
    input wire logic frame_collided,
    input wire logic frame_during_tx,
    output logic frame_accept,
    output logic frame_reject,
    // mii data between mac core and phy
    input wire logic [3:0] mac_txd,
    input wire logic mac_tx_en,
    output logic [3:0] phy_txd,
    output logic phy_tx_en,
    input wire logic [3:0] phy_rxd,
    input wire logic phy_rx_dv,
    output logic [3:0] mac_rxd,
    output logic mac_rx_dv,
    // mode levels to the mac core
    output logic heartbeat_check_en,
    output logic full_duplex,
    output logic internal_loopback
);

    // byte lane of the control word held at an indirect address
    function automatic logic [7:0] ctrl_lane(input logic [31:0] word,
                                             input logic [1:0] lane);
        logic [7:0] b;
        b = BYTE_ZERO;
        case (lane)
            2'h0: b = word[31:24];
            2'h1: b = word[23:16];
            2'h2: b = word[15:8];
            default: b = word[7:0];
        endcase
        return b;
    endfunction : ctrl_lane

    // true when an indirect address lands in the control word
    function automatic logic is_ctrl_addr(input logic [15:0] a);
        return a >= IND_CTRL_BASE
            && a < IND_CTRL_BASE + 16'(CTRL_LANES);
    endfunction : is_ctrl_addr

    logic [7:0] low_mark_q;
    logic [7:0] high_mark_q;
    logic [3:0] irq_en_q;
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [6:0] reject_ctl_q;
    logic [15:0] ind_wr_addr_q;
    logic [15:0] ind_rd_addr_q;
    logic [7:0] ind_rd_data_q;
    logic [31:0] ctrl_word_q;
    logic above_high_q;
    logic below_low_q;
    logic [DEPTH_BITS-1:0] high_bytes;
    logic [DEPTH_BITS-1:0] low_bytes;
    logic above_high;
    logic below_low;
    logic [3:0] events;
    logic status_rd;
    logic [1:0] wr_lane;
    logic [15:0] ind_wr_off;
    logic [3:0] rxd_meta_q;
    logic [3:0] rxd_sync_q;
    logic rx_dv_meta_q;
    logic rx_dv_sync_q;
    logic reject_any;
    logic addr_ok;

    // threshold byte locations; widths beyond the depth counter drop off
    assign high_bytes = DEPTH_BITS'({high_mark_q, MARK_SHIFT'(0)});
    assign low_bytes = DEPTH_BITS'({low_mark_q, MARK_SHIFT'(0)});
    assign above_high = queue_depth >= high_bytes;
    assign below_low = queue_depth < low_bytes;

    // level history so a crossing fires once per edge, not every cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            above_high_q <= 1'b0;
            below_low_q <= 1'b0;
        end else begin
            above_high_q <= above_high;
            below_low_q <= below_low;
        end
    end

    // events in status bit order
    always_comb begin
        events = 4'h0;
        events[ST_FIFO_OVF] = fifo_overflow;
        events[ST_QUEUE_OVF] = queue_overflow;
        events[ST_HIGH] = above_high && !above_high_q;
        events[ST_LOW] = below_low && !below_low_q;
    end

    assign status_rd = reg_rd && reg_addr == ADDR_STATUS;

    // read clears the snapshot, a same-cycle event still sets its bit
    always_comb begin
        status_d = status_q;
        if (status_rd) begin
            status_d = 4'h0;
        end
        status_d = status_d | events;
    end

    // status register; a read returns the value held before its clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_q <= 4'h0;
        end else begin
            status_q <= status_d;
        end
    end

    // enables follow their own bit order, so swap watermarks before gating
    // gating the next status lets irq drop at the edge of the clearing read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= (status_d[ST_FIFO_OVF] && irq_en_q[IE_FIFO_OVF])
                || (status_d[ST_QUEUE_OVF] && irq_en_q[IE_QUEUE_OVF])
                || (status_d[ST_HIGH] && irq_en_q[IE_HIGH])
                || (status_d[ST_LOW] && irq_en_q[IE_LOW]);
        end
    end

    // plain byte registers of the direct map
    // unmapped writes fall through every arm and change nothing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            low_mark_q <= BYTE_ZERO;
            high_mark_q <= BYTE_ZERO;
            irq_en_q <= 4'h0;
            reject_ctl_q <= 7'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_LOW_MARK) begin
                low_mark_q <= reg_wdata;
            end else if (reg_addr == ADDR_HIGH_MARK) begin
                high_mark_q <= reg_wdata;
            end else if (reg_addr == ADDR_IRQ_EN) begin
                irq_en_q <= reg_wdata[3:0];
            end else if (reg_addr == ADDR_REJECT_CTL) begin
                reject_ctl_q <= reg_wdata[6:0];
            end
        end
    end

    // indirect write address; data port writes land at this address
    // it does not step, so each lane needs its own address write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ind_wr_addr_q <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_IND_WR_HI) begin
                ind_wr_addr_q[15:8] <= reg_wdata;
            end else if (reg_addr == ADDR_IND_WR_LO) begin
                ind_wr_addr_q[7:0] <= reg_wdata;
            end
        end
    end

    // indirect read: writing the low address byte fetches the lane
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ind_rd_addr_q <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_IND_RD_HI) begin
                ind_rd_addr_q[15:8] <= reg_wdata;
            end else if (reg_addr == ADDR_IND_RD_LO) begin
                ind_rd_addr_q[7:0] <= reg_wdata;
            end
        end
    end

    assign ind_wr_off = ind_wr_addr_q - IND_CTRL_BASE;
    assign wr_lane = ind_wr_off[1:0];

    // fetched byte holds until the next fetch; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ind_rd_data_q <= BYTE_ZERO;
        end else if (reg_wr && reg_addr == ADDR_IND_RD_LO) begin
            if (is_ctrl_addr({ind_rd_addr_q[15:8], reg_wdata})) begin
                ind_rd_data_q <= ctrl_lane(ctrl_word_q,
                                           reg_wdata[1:0] - IND_CTRL_BASE[1:0]);
            end else begin
                ind_rd_data_q <= BYTE_ZERO;
            end
        end
    end

    // control word only through the indirect data port, one lane a write;
    // unimplemented bits stay zero, port select is stored as written
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_word_q <= CW_RESET;
        end else if (reg_wr && reg_addr == ADDR_IND_DATA
                     && is_ctrl_addr(ind_wr_addr_q)) begin
            case (wr_lane)
                2'h0: ctrl_word_q[31:24] <= reg_wdata & CW_IMPL_MASK[31:24];
                2'h1: ctrl_word_q[23:16] <= reg_wdata & CW_IMPL_MASK[23:16];
                2'h2: ctrl_word_q[15:8] <= reg_wdata & CW_IMPL_MASK[15:8];
                default: ctrl_word_q[7:0] <= reg_wdata & CW_IMPL_MASK[7:0];
            endcase
        end
    end

    // registered read data; one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_LOW_MARK) begin
                reg_rdata <= low_mark_q;
            end else if (reg_addr == ADDR_HIGH_MARK) begin
                reg_rdata <= high_mark_q;
            end else if (reg_addr == ADDR_IRQ_EN) begin
                reg_rdata <= {4'h0, irq_en_q};
            end else if (reg_addr == ADDR_STATUS) begin
                reg_rdata <= {4'h0, status_q & STATUS_MASK};
            end else if (reg_addr == ADDR_REJECT_CTL) begin
                reg_rdata <= {1'b0, reject_ctl_q};
            end else if (reg_addr == ADDR_IND_WR_HI) begin
                reg_rdata <= ind_wr_addr_q[15:8];
            end else if (reg_addr == ADDR_IND_WR_LO) begin
                reg_rdata <= ind_wr_addr_q[7:0];
            end else if (reg_addr == ADDR_IND_RD_HI) begin
                reg_rdata <= ind_rd_addr_q[15:8];
            end else if (reg_addr == ADDR_IND_RD_LO) begin
                reg_rdata <= ind_rd_addr_q[7:0];
            end else if (reg_addr == ADDR_IND_DATA) begin
                reg_rdata <= ind_rd_data_q;
            end else begin
                reg_rdata <= BYTE_ZERO;
            end
        end
    end

    // any reason to drop the frame; crc permit also covers mii errors
    always_comb begin
        reject_any = 1'b0;
        if (frame_ctrl && !reject_ctl_q[RJ_CTRL]) begin
            reject_any = 1'b1;
        end
        if (frame_ctrl && !frame_pause && !reject_ctl_q[RJ_NONPAUSE]) begin
            reject_any = 1'b1;
        end
        if (frame_len_err && !reject_ctl_q[RJ_LEN]) begin
            reject_any = 1'b1;
        end
        if (frame_crc_err && !reject_ctl_q[RJ_CRC]) begin
            reject_any = 1'b1;
        end
        if (frame_mii_err && !reject_ctl_q[RJ_MII]
            && !reject_ctl_q[RJ_CRC]) begin
            reject_any = 1'b1;
        end
        if (frame_dribble && !frame_runt && !frame_collided
            && !reject_ctl_q[RJ_DRIBBLE]) begin
            reject_any = 1'b1;
        end
        if (frame_bcast && !reject_ctl_q[RJ_BCAST]) begin
            reject_any = 1'b1;
        end
        if (frame_during_tx && ctrl_word_q[CW_IGNORE_OWN]) begin
            reject_any = 1'b1;
        end
    end

    // destination filter: own address, broadcast, or the pass modes
    assign addr_ok = frame_addr_match || frame_bcast
        || ctrl_word_q[CW_PROMISC]
        || (frame_mcast && ctrl_word_q[CW_ALL_MCAST]);

    // one verdict pulse per finished frame
    // a missed destination counts as a reject, so exactly one pulse fires
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_accept <= 1'b0;
            frame_reject <= 1'b0;
        end else begin
            frame_accept <= frame_done && addr_ok && !reject_any;
            frame_reject <= frame_done && !(addr_ok && !reject_any);
        end
    end

    // phy receive pins are asynchronous; two stages before use
    // only the second stage is read, the first may still be settling
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxd_meta_q <= 4'h0;
            rxd_sync_q <= 4'h0;
            rx_dv_meta_q <= 1'b0;
            rx_dv_sync_q <= 1'b0;
        end else begin
            rxd_meta_q <= phy_rxd;
            rxd_sync_q <= rxd_meta_q;
            rx_dv_meta_q <= phy_rx_dv;
            rx_dv_sync_q <= rx_dv_meta_q;
        end
    end

    // loopback turns transmit back inward and keeps the phy silent
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phy_txd <= 4'h0;
            phy_tx_en <= 1'b0;
            mac_rxd <= 4'h0;
            mac_rx_dv <= 1'b0;
        end else if (ctrl_word_q[CW_LOOPBACK]) begin
            phy_txd <= 4'h0;
            phy_tx_en <= 1'b0;
            mac_rxd <= mac_txd;
            mac_rx_dv <= mac_tx_en;
        end else begin
            phy_txd <= mac_txd;
            phy_tx_en <= mac_tx_en;
            mac_rxd <= rxd_sync_q;
            mac_rx_dv <= rx_dv_sync_q;
        end
    end

    // mode levels; full duplex also suppresses the heartbeat check
    // registered, so a mode lands one cycle after the control word write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            heartbeat_check_en <= 1'b0;
            full_duplex <= 1'b0;
            internal_loopback <= 1'b0;
        end else begin
            heartbeat_check_en <= !ctrl_word_q[CW_HEARTBEAT_OFF]
                && !ctrl_word_q[CW_FULL_DUPLEX];
            full_duplex <= ctrl_word_q[CW_FULL_DUPLEX];
            internal_loopback <= ctrl_word_q[CW_LOOPBACK];
        end
    end

endmodule : rxq_filter

// ===== tb/rxq_filter_chk.sv
// port checker for the receive queue filter: frame verdicts, mii path
// assumes one clock domain and the synchronous active-low rst_b
`timescale 1ns/1ps

module rxq_filter_chk
    import rxq_filter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [8:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic queue_overflow,
    input wire logic fifo_overflow,
    input wire logic frame_done,
    input wire logic frame_accept,
    input wire logic frame_reject,
    input wire logic [3:0] mac_txd,
    input wire logic mac_tx_en,
    input wire logic [3:0] phy_txd,
    input wire logic phy_tx_en,
    input wire logic [3:0] phy_rxd,
    input wire logic [3:0] mac_rxd,
    input wire logic internal_loopback
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] run_q;
    logic st_rd;
    logic no_ev;

    assign st_rd = reg_rd && reg_addr == ADDR_STATUS;
    assign no_ev = !fifo_overflow && !queue_overflow;

    // cycles out of loopback; the pin path needs three to refill
    always_ff @(posedge clk) begin
        if (!rst_b || internal_loopback) run_q <= 3'h0;
        else if (run_q != 3'h4) run_q <= run_q + 3'h1;
    end

    a_verdict_once:
        assert property (frame_done |=> frame_accept != frame_reject)
        else $error("frame verdict not exactly one");
    a_verdict_idle:
        assert property (!frame_done |=> !frame_accept && !frame_reject)
        else $error("frame verdict without frame");
    a_loop_tx_off:
        assert property (internal_loopback && $past(internal_loopback)
            |-> !phy_tx_en && phy_txd == 4'h0)
        else $error("phy transmit active in loopback");
    a_loop_rx_copy:
        assert property (internal_loopback && $past(internal_loopback)
            |-> mac_rxd == $past(mac_txd))
        else $error("loopback receive data wrong");
    a_tx_pass:
        assert property (!internal_loopback && !$past(internal_loopback)
            |-> phy_txd == $past(mac_txd) && phy_tx_en == $past(mac_tx_en))
        else $error("phy transmit not a copy");
    a_rx_sync:
        assert property (run_q == 3'h4 && !internal_loopback
            |-> mac_rxd == $past(phy_rxd, 3))
        else $error("receive pins not three cycles late");
    a_unmapped_zero:
        assert property (reg_rd && reg_addr == 9'h000 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_clear:
        assert property (st_rd && no_ev ##1 no_ev ##1 st_rd
            |=> reg_rdata[3:2] == 2'b00)
        else $error("overflow status survived a read");

    c_accept: cover property (frame_accept);
    c_reject: cover property (frame_reject);
    c_loop: cover property (internal_loopback && mac_tx_en);
endmodule : rxq_filter_chk

bind rxq_filter rxq_filter_chk u_chk (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .queue_overflow(queue_overflow), .fifo_overflow(fifo_overflow),
    .frame_done(frame_done), .frame_accept(frame_accept),
    .frame_reject(frame_reject), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
    .phy_txd(phy_txd), .phy_tx_en(phy_tx_en), .phy_rxd(phy_rxd),
    .mac_rxd(mac_rxd), .internal_loopback(internal_loopback));

// ===== tb/phy_model.sv
// mii phy stand-in: one eight-nibble receive frame per start pulse
// assumes start is raised for one cycle just after a clk edge
`timescale 1ns/1ps

module phy_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [3:0] nib,
    input wire logic phy_tx_en,
    output logic [3:0] phy_rxd,
    output logic phy_rx_dv,
    output int tx_cycles
);
    int left;
    // pins move 3 ns after the edge, as an unrelated phy would
    initial begin
        phy_rxd = 4'h0;
        phy_rx_dv = 1'b0;
        tx_cycles = 0;
        left = 0;
        forever begin
            @(posedge clk);
            #3;
            // count the transmit enable once it has settled after the edge
            if (phy_tx_en) tx_cycles++;
            if (start) left = 8;
            phy_rx_dv = left > 0;
            // idle data toggles so stale nibbles never match
            phy_rxd = left > 0 ? nib : ~phy_rxd;
            if (left > 0) left--;
        end
    end
endmodule : phy_model

// ===== tb/rxq_filter_tb_top.sv
// testbench for the receive queue filter, register port driven directly
// assumes 40 MHz clk and a phy model on the mii pins
`timescale 1ns/1ps

module rxq_filter_tb_top;
    import rxq_filter_pkg::*;
    logic clk, rst_b, reg_wr, reg_rd, qovf, fovf, fdone, start, tx_en;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [23:0] depth;
    logic [11:0] fl;
    logic [3:0] txd, nib, phy_txd, phy_rxd, mac_rxd;
    logic irq, f_acc, f_rej, phy_tx_en, phy_rx_dv, mac_rx_dv, hb, fd, lb;
    int err_total, total_checks, cyc, txc;

    rxq_filter uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq(irq), .queue_depth(depth),
        .queue_overflow(qovf), .fifo_overflow(fovf), .frame_done(fdone),
        .frame_ctrl(fl[0]), .frame_pause(fl[1]), .frame_len_err(fl[2]),
        .frame_crc_err(fl[3]), .frame_dribble(fl[4]), .frame_mii_err(fl[5]),
        .frame_bcast(fl[6]), .frame_mcast(fl[7]), .frame_addr_match(fl[8]),
        .frame_runt(fl[9]), .frame_collided(fl[10]),
        .frame_during_tx(fl[11]), .frame_accept(f_acc),
        .frame_reject(f_rej), .mac_txd(txd), .mac_tx_en(tx_en),
        .phy_txd(phy_txd), .phy_tx_en(phy_tx_en), .phy_rxd(phy_rxd),
        .phy_rx_dv(phy_rx_dv), .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv),
        .heartbeat_check_en(hb), .full_duplex(fd), .internal_loopback(lb));
    phy_model u_phy (.clk(clk), .start(start), .nib(nib),
        .phy_tx_en(phy_tx_en), .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv),
        .tx_cycles(txc));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim;
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // the whole run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(logic [8:0] a, logic [7:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rdc(logic [8:0] a, logic [7:0] e);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check("rdata", reg_rdata, e);
    endtask : rdc

    // control word lanes go through the indirect address pair
    task automatic cw_wr(logic [1:0] ln, logic [7:0] d);
        wr(ADDR_IND_WR_HI, IND_CTRL_BASE[15:8]);
        wr(ADDR_IND_WR_LO, IND_CTRL_BASE[7:0] | 8'(ln));
        wr(ADDR_IND_DATA, d);
    endtask : cw_wr

    task automatic cw_rd(logic [1:0] ln, logic [7:0] e);
        wr(ADDR_IND_RD_HI, IND_CTRL_BASE[15:8]);
        wr(ADDR_IND_RD_LO, IND_CTRL_BASE[7:0] | 8'(ln));
        rdc(ADDR_IND_DATA, e);
    endtask : cw_rd

    task automatic t_reset;
        check("mode", {hb, fd, lb}, 3'b100);
        cw_rd(2'd1, 8'h08);
        cw_rd(2'd0, 8'h00);
        rdc(ADDR_LOW_MARK, 8'h00);
        rdc(ADDR_HIGH_MARK, 8'h00);
        rdc(ADDR_REJECT_CTL, 8'h00);
        wr(ADDR_IRQ_EN, 8'hff);
        rdc(ADDR_IRQ_EN, 8'h0f);
        wr(9'h000, 8'hff);
        rdc(9'h000, 8'h00);
    endtask : t_reset

    task automatic pulse_irq(logic f, logic [7:0] st, logic ex);
        fovf = f;
        qovf = !f;
        tick(1);
        fovf = 1'b0;
        qovf = 1'b0;
        check("irq", irq, ex);
        rdc(ADDR_STATUS, st);
        check("irq", irq, 1'b0);
        rdc(ADDR_STATUS, 8'h00);
    endtask : pulse_irq

    task automatic t_irq;
        rdc(ADDR_STATUS, 8'h02);
        wr(ADDR_IRQ_EN, 8'h08);
        pulse_irq(1'b1, 8'h08, 1'b1);
        pulse_irq(1'b0, 8'h04, 1'b0);
        wr(ADDR_HIGH_MARK, 8'h02);
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_LOW_MARK, 8'h01);
        tick(2);
        check("irq", irq, 1'b0);
        rdc(ADDR_STATUS, 8'h01);
        depth = 24'h01ffff;
        tick(3);
        rdc(ADDR_STATUS, 8'h00);
        depth = 24'h020000;
        tick(3);
        check("irq", irq, 1'b1);
        rdc(ADDR_STATUS, 8'h02);
        wr(ADDR_IRQ_EN, 8'h02);
        depth = 24'h00ffff;
        tick(3);
        check("irq", irq, 1'b1);
        rdc(ADDR_STATUS, 8'h01);
    endtask : t_irq

    task automatic t_ctrl;
        cw_wr(2'd0, 8'hf7);
        cw_wr(2'd1, 8'hff);
        cw_wr(2'd2, 8'hff);
        cw_wr(2'd3, 8'hff);
        cw_rd(2'd0, 8'h10);
        cw_rd(2'd1, 8'hbc);
        cw_rd(2'd2, 8'h00);
        cw_rd(2'd3, 8'h00);
        check("mode", {hb, fd, lb}, 3'b011);
        cw_wr(2'd1, 8'h08);
        tick(1);
        check("mode", {hb, fd, lb}, 3'b000);
        cw_wr(2'd0, 8'h00);
        tick(1);
        check("mode", {hb, fd, lb}, 3'b100);
        cw_wr(2'd1, 8'h18);
        tick(1);
        check("mode", {hb, fd, lb}, 3'b010);
    endtask : t_ctrl

    task automatic t_mii;
        int n;
        nib = 4'ha;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(4);
        check("rx", {mac_rx_dv, mac_rxd}, 5'h1a);
        txd = 4'h5;
        tx_en = 1'b1;
        tick(1);
        check("tx", {phy_tx_en, phy_txd}, 5'h15);
        cw_wr(2'd1, 8'h28);
        tick(2);
        n = txc;
        check("loop rx", {mac_rx_dv, mac_rxd}, 5'h15);
        tick(4);
        check("phy tx", txc, n);
        cw_wr(2'd1, 8'h08);
        tx_en = 1'b0;
    endtask : t_mii

    task automatic frame(logic [7:0] rc, logic [11:0] f, logic acc);
        wr(ADDR_REJECT_CTL, rc);
        fl = f;
        fdone = 1'b1;
        tick(1);
        fdone = 1'b0;
        fl = 12'h000;
        check("accept", f_acc, acc);
        check("reject", f_rej, !acc);
    endtask : frame

    task automatic t_filter;
        frame(8'h00, 12'h100, 1'b1);
        frame(8'h00, 12'h003, 1'b0);
        frame(8'h20, 12'h003, 1'b1);
        frame(8'h20, 12'h001, 1'b0);
        frame(8'h60, 12'h001, 1'b1);
        frame(8'h00, 12'h004, 1'b0);
        frame(8'h10, 12'h004, 1'b1);
        frame(8'h00, 12'h008, 1'b0);
        frame(8'h08, 12'h028, 1'b1);
        frame(8'h00, 12'h010, 1'b0);
        frame(8'h00, 12'h210, 1'b1);
        frame(8'h00, 12'h410, 1'b1);
        frame(8'h04, 12'h010, 1'b1);
        frame(8'h00, 12'h020, 1'b0);
        frame(8'h02, 12'h020, 1'b1);
        frame(8'h00, 12'h040, 1'b0);
        frame(8'h01, 12'h040, 1'b1);
        cw_wr(2'd1, 8'h00);
        frame(8'h00, 12'h080, 1'b0);
        cw_wr(2'd1, 8'h04);
        frame(8'h00, 12'h080, 1'b1);
        cw_wr(2'd1, 8'h80);
        frame(8'h00, 12'h900, 1'b0);
        frame(8'h00, 12'h100, 1'b1);
    endtask : t_filter

    initial begin
        {rst_b, reg_wr, reg_rd, qovf, fovf, fdone, start, tx_en} = 8'h00;
        {reg_addr, reg_wdata, depth, fl, txd, nib} = 61'h0;
        {err_total, total_checks, cyc} = 96'h0;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        tick(2);
        t_reset();
        t_irq();
        t_ctrl();
        t_mii();
        t_filter();
        end_sim();
    end
endmodule : rxq_filter_tb_top
